// file: logic/phase_monitor.sv
// Purpose: per-phase current and voltage waveform monitoring with host registers
// Assumes: sample_stb_i marks one new sample set on all phases at the 26.0 kSPS base rate
// Notes:   register port stands for the serial interface after byte assembly
`include "phase_monitor_consts.svh"
module phase_monitor
    import phase_monitor_pkg::*;
#(
    parameter int         FIFO_DEPTH = 4,
    parameter logic [7:0] HALF_CYCLES = `PEAK_HALF_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              sample_stb_i,
    input  wire logic [2:0][23:0]  i_sample_i,
    input  wire logic [2:0][15:0]  v_sample_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [23:0]       reg_wdata_i,
    output logic      [23:0]       reg_rdata_o,
    output logic                   irq_n_o,
    output logic      [2:0][15:0]  v_power_o,
    output logic      [2:0][23:0]  i_power_o,
    output logic      [2:0][15:0]  v_rms_o,
    output logic      [7:0]        wave_byte_o,
    output logic                   wave_byte_valid_o,
    input  wire logic              wave_byte_ready_i
);
    // control registers
    logic [7:0]  gain_q, measurement_mode_reg_q, wmode_q, lcmode_q, thr_q, peak_current_value_q, track_q, half_q;
    logic [23:0] mask_q, status_q, waveform_sample_q;
    logic [2:0][23:0] integ_q;
    logic [2:0][15:0] lpf_q;
    logic [2:0]  neg_q;
    logic [2:0]  rate_q;
    logic [15:0] hold_q;
    ser_state_type ser_q;

    function automatic logic [7:0] peak_code(input logic [23:0] s);
        logic [23:0] a;
        a = s[23] ? (~s + 24'h000001) : s;
        return a[`PEAK_CODE_LSB +: 8];
    endfunction

    wire wr_en    = ce_i && reg_wr_i;
    wire rd_en    = ce_i && reg_rd_i;
    wire stb      = ce_i && sample_stb_i;
    wire integ_on = gain_q[`GAIN_INTEG_BIT];
    wire [2:0] peak_sel = measurement_mode_reg_q[`MM_PEAK_PHASE_SELECT_LSB +: 3];
    wire [2:0] oc_sel   = measurement_mode_reg_q[`MM_OCSEL_LSB +: 3];
    wire [2:0] zx_sel   = lcmode_q[2:0];
    wire [2:0] wav_sel  = wmode_q[`WM_WAVEFORM_SOURCE_SELECT_LSB +: 3];
    wire [1:0] ph_sel   = wmode_q[`WM_SAMPLE_PHASE_SELECT_LSB +: 2];
    wire [1:0] rate_sel = wmode_q[`WM_RATE_LSB +: 2];

    // per-phase current, filtered voltage and crossing logic
    logic [2:0][23:0] icur;
    logic [2:0][15:0] lpf_d;
    logic [2:0][7:0]  icode;
    logic [2:0]       pos_x;
    logic [2:0]       any_x;
    logic [2:0]       oc_hit;
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            // leaky accumulator: a pure integrator would run away on any dc offset
            wire [27:0] acc_ext = {{4{integ_q[p][23]}}, integ_q[p]};
            wire [27:0] in_ext  = {{4{i_sample_i[p][23]}}, i_sample_i[p]};
            // shifts sit in signed wires so a negative sample or state stays negative
            wire signed [27:0] in_shr  = $signed(in_ext) >>> `INTEG_OUT_SHIFT;
            wire signed [27:0] acc_shr = $signed(acc_ext) >>> `INTEG_LEAK_SHIFT;
            wire [27:0] acc_sum = acc_ext + in_shr - acc_shr;
            wire [16:0] diff = {v_sample_i[p][15], v_sample_i[p]}
                               - {lpf_q[p][15], lpf_q[p]};
            wire [16:0] step = $signed(diff) >>> `LPF_SHIFT;
            assign lpf_d[p]  = lpf_q[p] + step[15:0];                    // see [RULE12]
            assign icur[p]   = integ_on ? integ_q[p] : i_sample_i[p];     // see [RULE1]
            assign icode[p]  = peak_code(icur[p]);                        // see [RULE4]
            assign oc_hit[p] = oc_sel[p] && (icode[p] > thr_q);           // see [RULE10]
            assign pos_x[p]  = neg_q[p] && !lpf_q[p][15];                 // see [RULE20]
            assign any_x[p]  = neg_q[p] != lpf_q[p][15];                  // see [RULE19]
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    integ_q[p] <= '0;
                    lpf_q[p]   <= '0;
                    neg_q[p]   <= 1'b0;
                end else if (stb) begin
                    integ_q[p] <= acc_sum[23:0];                          // see [RULE2]
                    lpf_q[p]   <= lpf_d[p];
                    neg_q[p]   <= lpf_q[p][15];
                end
            end
        end
    endgenerate

    // peak over selected phases, window counted in half cycles
    logic [7:0] sel_max;
    always_comb begin
        sel_max = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if (peak_sel[k] && icode[k] > sel_max) sel_max = icode[k];   // see [RULE5]
        end
    end
    wire half_evt   = stb && |(any_x & zx_sel);                           // see [RULE7]
    wire win_end    = half_evt && (half_q == HALF_CYCLES - 8'h01);
    wire [7:0] track_now = (sel_max > track_q) ? sel_max : track_q;       // see [RULE3]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_q  <= '0;
            track_q <= '0;
            peak_current_value_q <= '0;
        end else if (ce_i) begin
            if (half_evt) half_q <= win_end ? 8'h00 : half_q + 8'h01;
            if (win_end) begin
                peak_current_value_q <= track_now;                                     // see [RULE6]
                track_q <= 8'h00;                                         // see [RULE23]
            end else if (stb) begin
                track_q <= track_now;
            end
        end
    end

    // waveform capture at the selected rate into the buffer
    stream_if #(.WIDTH(24)) wave_ch ();
    wire [2:0] rate_mask = (3'h1 << rate_sel) - 3'h1;                     // see [RULE16]
    wire       rate_tick = stb && ((rate_q & rate_mask) == 3'h0);
    wire       wave_on   = (wav_sel == `WAVEFORM_SOURCE_SELECT_VOLTAGE) && (ph_sel != 2'h3);
    wire [15:0] wave_v   = lpf_q[ph_sel[1] ? 2 : (ph_sel[0] ? 1 : 0)];
    wire       capture   = rate_tick && wave_on && wave_ch.push_ready;    // see [RULE15]
    assign wave_ch.push_valid = capture;
    assign wave_ch.push_data  = {{8{wave_v[15]}}, wave_v};                // see [RULE13]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rate_q  <= '0;
            waveform_sample_q <= '0;
        end else if (ce_i) begin
            if (stb) rate_q <= rate_q + 3'h1;
            if (capture) waveform_sample_q <= wave_ch.push_data;
        end
    end

    word_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .ch    (wave_ch.buffer)
    );

    // byte serializer, most significant byte first; holds on byte ready
    wire byte_take = wave_byte_valid_o && wave_byte_ready_i;
    assign wave_ch.pop_ready = ce_i && (ser_q == ser_idle) && (!wave_byte_valid_o || byte_take);
    wire pop_now = wave_ch.pop_ready && wave_ch.pop_valid;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ser_q             <= ser_idle;
            hold_q            <= '0;
            wave_byte_o       <= '0;
            wave_byte_valid_o <= 1'b0;
        end else if (ce_i) begin
            case (ser_q)
                ser_idle: begin
                    if (pop_now) begin
                        wave_byte_o       <= wave_ch.pop_data[23:16];     // see [RULE18]
                        hold_q            <= wave_ch.pop_data[15:0];
                        wave_byte_valid_o <= 1'b1;
                        ser_q             <= ser_mid;
                    end else if (byte_take) begin
                        wave_byte_valid_o <= 1'b0;
                    end
                end
                ser_mid: begin
                    if (byte_take) begin
                        wave_byte_o <= hold_q[15:8];
                        ser_q       <= ser_low;
                    end
                end
                ser_low: begin
                    if (byte_take) begin
                        wave_byte_o <= hold_q[7:0];
                        ser_q       <= ser_idle;
                    end
                end
                default: begin
                    ser_q <= ser_idle;
                end
            endcase
        end
    end

    // status flags: a new event beats the clear-on-read in the same cycle
    logic [23:0] events;
    always_comb begin
        events = 24'h000000;
        events[`ST_ZX_LSB +: 3] = stb ? (pos_x & 3'h7) : 3'h0;           // see [RULE21]
        events[`ST_OC_BIT]      = stb && |oc_hit;                         // see [RULE9]
        events[`ST_SAMPLE_READY_MASK_BIT]    = capture;                                // see [RULE17]
    end
    wire clr_rd = rd_en && (reg_addr_i == `ADDR_STATUS_CLR);             // see [RULE22]

    // register read mux
    logic [23:0] rd_mux;
    always_comb begin
        if (reg_addr_i == `ADDR_WAVEFORM) rd_mux = waveform_sample_q;
        else if (reg_addr_i == `ADDR_PEAK_CURRENT) rd_mux = {16'h0000, peak_current_value_q};
        else if (reg_addr_i == `ADDR_MEAS_MODE) rd_mux = {16'h0000, measurement_mode_reg_q};
        else if (reg_addr_i == `ADDR_WAVE_MODE) rd_mux = {16'h0000, wmode_q};
        else if (reg_addr_i == `ADDR_LINE_CYCLE) rd_mux = {16'h0000, lcmode_q};
        else if (reg_addr_i == `ADDR_MASK) rd_mux = mask_q;
        else if (reg_addr_i == `ADDR_STATUS) rd_mux = status_q;
        else if (reg_addr_i == `ADDR_STATUS_CLR) rd_mux = status_q;
        else if (reg_addr_i == `ADDR_OC_THRESHOLD) rd_mux = {16'h0000, thr_q};
        else if (reg_addr_i == `ADDR_GAIN) rd_mux = {16'h0000, gain_q};
        else rd_mux = 24'h000000;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_q      <= '0;
            measurement_mode_reg_q     <= '0;
            wmode_q     <= '0;
            lcmode_q    <= '0;
            thr_q       <= '0;
            mask_q      <= '0;
            status_q    <= '0;
            reg_rdata_o <= '0;
            irq_n_o     <= 1'b1;
        end else if (ce_i) begin
            if (wr_en && reg_addr_i == `ADDR_GAIN) gain_q <= reg_wdata_i[7:0];
            if (wr_en && reg_addr_i == `ADDR_MEAS_MODE) measurement_mode_reg_q <= reg_wdata_i[7:0];
            if (wr_en && reg_addr_i == `ADDR_WAVE_MODE) wmode_q <= reg_wdata_i[7:0];
            if (wr_en && reg_addr_i == `ADDR_LINE_CYCLE) lcmode_q <= reg_wdata_i[7:0];
            if (wr_en && reg_addr_i == `ADDR_OC_THRESHOLD) thr_q <= reg_wdata_i[7:0]; // see [RULE8]
            if (wr_en && reg_addr_i == `ADDR_MASK) mask_q <= reg_wdata_i;
            if (rd_en) reg_rdata_o <= rd_mux;
            status_q <= (clr_rd ? 24'h000000 : status_q) | events;
            irq_n_o  <= ~|(status_q & mask_q);
        end
    end

    // measurement feeds: raw voltage for power, filtered voltage for rms/apparent
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            v_power_o <= '0;
            i_power_o <= '0;
            v_rms_o   <= '0;
        end else if (stb) begin
            v_power_o <= v_sample_i;                                      // see [RULE11]
            i_power_o <= icur;
            v_rms_o   <= lpf_d;                                           // see [RULE14]
        end
    end

    // checks
    property p_integ_bypass;
        @(posedge clk_i) disable iff (rst_i)
        (stb && !integ_on) |=> (i_power_o == $past(i_sample_i));
    endproperty
    a_integ_bypass: assert property (p_integ_bypass) else $error("raw current not passed"); // [RULE1]

    property p_peak_window;
        @(posedge clk_i) disable iff (rst_i)
        win_end |=> (peak_current_value_q == $past(track_now)) && (track_q == 8'h00);
    endproperty
    a_peak_window: assert property (p_peak_window) else $error("peak window not latched"); // [RULE23]

    property p_overcurrent;
        @(posedge clk_i) disable iff (rst_i)
        (stb && |oc_hit) |=> status_q[`ST_OC_BIT] ##1 (!mask_q[`ST_OC_BIT] || !irq_n_o);
    endproperty
    a_overcurrent: assert property (p_overcurrent) else $error("overcurrent not flagged"); // [RULE9]

    property p_zx_flag;
        @(posedge clk_i) disable iff (rst_i)
        (stb && pos_x[0]) |=> status_q[`ST_ZX_LSB];
    endproperty
    a_zx_flag: assert property (p_zx_flag) else $error("crossing flag missing"); // [RULE20]

    property p_zx_only_rising;
        @(posedge clk_i) disable iff (rst_i)
        (!status_q[`ST_ZX_LSB] && !(stb && pos_x[0])) |=> !status_q[`ST_ZX_LSB];
    endproperty
    a_zx_only_rising: assert property (p_zx_only_rising) else $error("spurious crossing flag"); // [RULE20]

    property p_clear_on_read;
        @(posedge clk_i) disable iff (rst_i)
        (clr_rd && !stb) |=> (status_q[`ST_ZX_LSB +: 3] == 3'h0);
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("status not cleared"); // [RULE21]

    property p_irq_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && |(status_q & mask_q) && !clr_rd) |=> !irq_n_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt released early"); // [RULE22]

    property p_sign_ext;
        @(posedge clk_i) disable iff (rst_i)
        capture |=> (waveform_sample_q[23:16] == {8{waveform_sample_q[15]}});
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("waveform not sign extended"); // [RULE13]

    property p_msb_first;
        @(posedge clk_i) disable iff (rst_i)
        pop_now |=> (wave_byte_o == $past(wave_ch.pop_data[23:16])) && wave_byte_valid_o;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("top byte not first"); // [RULE18]

    property p_no_capture_off;
        @(posedge clk_i) disable iff (rst_i)
        (wav_sel != `WAVEFORM_SOURCE_SELECT_VOLTAGE) |-> !capture;
    endproperty
    a_no_capture_off: assert property (p_no_capture_off) else $error("capture while off"); // [RULE15]

    c_window:  cover property (@(posedge clk_i) disable iff (rst_i) win_end);
    c_capture: cover property (@(posedge clk_i) disable iff (rst_i) capture ##[1:20] byte_take);
    c_oc_irq:  cover property (@(posedge clk_i) disable iff (rst_i) events[`ST_OC_BIT] ##2 !irq_n_o);
endmodule

// file: logic/phase_monitor_consts.svh
// Purpose: offsets, field positions, select codes, shifts and timing counts of the phase monitor
// Assumes: 8-bit register address, 24-bit register data, 100 MHz clock
// Notes:   definitions only
// Overview of operation
// [RULE1] integrator is off after reset; gain register bit 7 turns it on
// [RULE2] enabled integrator gives -20 dB/dec slope and about 90 degree lag
// [RULE3] peak current result keeps the largest absolute current over a window of HALF_CYCLES half cycles
// [RULE4] peak current result holds sample bits 14 to 21; full scale gives 0xA1
// [RULE5] three peak phase select bits pick phases; several may be on together
// [RULE6] voltage and current peaks are tracked independently across selected phases; the code tracks only the current peak
// [RULE7] half cycles come from crossings on phases picked by the crossing source field
// [RULE8] overcurrent threshold is compared with current sample bits 14 to 21
// [RULE9] overcurrent sets status bit 15; interrupt goes low if its mask bit is 1
// [RULE10] overcurrent phase select field picks phases; any one above threshold sets flag
// [RULE11] power path takes raw voltage samples, unfiltered and without offset removal
// [RULE12] waveform voltage passes a single-pole low-pass with 260 Hz cutoff
// [RULE13] filtered voltage is 16-bit twos complement, sign-extended to 24 bits
// [RULE14] low-pass output feeds waveform, rms and apparent paths, not active or reactive
// [RULE15] waveform source select 001 starts voltage sampling of the chosen phase
// [RULE16] waveform mode bits 5 and 6 pick 26.0, 13.0, 6.5 or 3.3 kSPS
// [RULE17] with sample-ready mask set, interrupt goes low on every new waveform sample
// [RULE18] waveform words leave as three bytes, most significant first, top byte sign
// [RULE19] crossing signal comes from the low-pass output and drives line-cycle counting
// [RULE20] only negative-to-positive crossings set status bits 9 to 11
// [RULE21] reading the clear-on-read status clears crossing flags; one flag and mask each
// [RULE22] interrupt stays low until the clear-on-read status register is read
// [RULE23] peak tracking restarts at the start of every window
`ifndef PHASE_MONITOR_CONSTS_SVH
`define PHASE_MONITOR_CONSTS_SVH
`define ADDR_WAVEFORM      8'h01
`define ADDR_PEAK_CURRENT  8'h0F
`define ADDR_MEAS_MODE     8'h14
`define ADDR_WAVE_MODE     8'h15
`define ADDR_LINE_CYCLE    8'h17
`define ADDR_MASK          8'h18
`define ADDR_STATUS        8'h19
`define ADDR_STATUS_CLR    8'h1A
`define ADDR_OC_THRESHOLD  8'h1D
`define ADDR_GAIN          8'h23
`define GAIN_INTEG_BIT     7
`define MM_OCSEL_LSB       0
`define MM_PEAK_PHASE_SELECT_LSB     2
`define WM_WAVEFORM_SOURCE_SELECT_LSB      0
`define WM_SAMPLE_PHASE_SELECT_LSB       3
`define WM_RATE_LSB        5
`define WAVEFORM_SOURCE_SELECT_VOLTAGE     3'h1
`define ST_ZX_LSB          9
`define ST_OC_BIT          15
`define ST_SAMPLE_READY_MASK_BIT        16
`define PEAK_CODE_LSB      14
`define PEAK_HALF_CYCLES   8'h08
`define LPF_SHIFT          4
`define INTEG_LEAK_SHIFT   10
`define INTEG_OUT_SHIFT    4
`endif

// file: logic/phase_monitor_pkg.sv
// Purpose: shared types of the phase monitor
// Assumes: nothing
// Notes:   constants live in the consts header
package phase_monitor_pkg;
    typedef enum logic [1:0] {ser_idle, ser_mid, ser_low} ser_state_type;
    typedef logic [23:0] word_type;
endpackage

// file: logic/stream_if.sv
// Purpose: valid/ready word channel between monitor and its buffer
// Assumes: single clock
// Notes:   push side fills, pop side drains
interface stream_if #(parameter int WIDTH = 24);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport buffer (input push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data);
    modport user   (output push_valid, push_data, pop_ready,
                    input push_ready, pop_valid, pop_data);
endinterface

// file: logic/word_fifo.sv
// Purpose: small flip-flop FIFO for waveform words
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from an occupancy count
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   ce_i,
    stream_if.buffer    ch
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              do_push = ce_i && ch.push_valid && ch.push_ready;
    wire              do_pop  = ce_i && ch.pop_valid && ch.pop_ready;
    assign ch.push_ready = (cnt_q != (AW+1)'(DEPTH));
    assign ch.pop_valid  = (cnt_q != '0);
    assign ch.pop_data   = mem_q[rd_q];
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= ch.push_data;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wr_q <= wr_q + 1'b1;
            if (do_pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// file: verif/host_model.sv
// Purpose: consumer of the waveform byte stream, assembling 24-bit words
// Assumes: bytes arrive most significant first, three to a word
// Notes:   mode 0 always ready, 1 random stalls, 2 full stall
module host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        valid_i,
    input  wire logic [1:0]  mode_i,
    output logic             ready_o,
    output logic      [23:0] word_o,
    output logic             word_stb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  cnt_q;
    logic [15:0] acc_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q      <= 2'h0;
            acc_q      <= 16'h0000;
            ready_o    <= 1'b0;
            word_o     <= 24'h000000;
            word_stb_o <= 1'b0;
        end else begin
            word_stb_o <= 1'b0;
            // ready only moves right after an edge, so a byte is never half taken
            ready_o    <= (mode_i == 2'h0) ? 1'b1 :
                          (mode_i == 2'h1) ? 1'($urandom_range(1, 0)) : 1'b0;
            if (valid_i && ready_o) begin
                if (cnt_q == 2'h2) begin
                    word_o     <= {acc_q, byte_i};
                    word_stb_o <= 1'b1;
                    cnt_q      <= 2'h0;
                end else begin
                    acc_q <= {acc_q[7:0], byte_i};
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule

// file: verif/test_phase_monitor.sv
// Purpose: self-checking bench for the phase monitor
// Assumes: low-pass model y += (x - y) >>> 4 per strobe, window of 2 half cycles
// Notes:   only phase A current is driven; all voltage phases share one value
`include "phase_monitor_consts.svh"
module test_phase_monitor
    import phase_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk_i, rst_i, ce_i, sample_stb_i, reg_wr_i, reg_rd_i, irq_n_o;
    logic             wave_byte_valid_o, wave_byte_ready_i, word_stb, integ;
    logic [2:0][23:0] i_sample_i, i_power_o;
    logic [2:0][15:0] v_sample_i, v_power_o, v_rms_o;
    logic [7:0]       reg_addr_i, wave_byte_o;
    logic [23:0]      reg_wdata_i, reg_rdata_o, word, d;
    logic [1:0]       host_mode;
    logic [15:0]      hist[$];
    logic [23:0]      words[$];
    int               num_errors, num_checks, y, found, acc;

    phase_monitor #(.FIFO_DEPTH(4), .HALF_CYCLES(8'h02)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sample_stb_i(sample_stb_i),
        .i_sample_i(i_sample_i), .v_sample_i(v_sample_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .irq_n_o(irq_n_o), .v_power_o(v_power_o),
        .i_power_o(i_power_o), .v_rms_o(v_rms_o), .wave_byte_o(wave_byte_o),
        .wave_byte_valid_o(wave_byte_valid_o), .wave_byte_ready_i(wave_byte_ready_i));
    host_model u_host (
        .clk_i(clk_i), .rst_i(rst_i), .byte_i(wave_byte_o), .valid_i(wave_byte_valid_o),
        .mode_i(host_mode), .ready_o(wave_byte_ready_i), .word_o(word),
        .word_stb_o(word_stb));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (word_stb === 1'b1) words.push_back(word);

    task automatic conclude();
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        @(negedge clk_i);
        reg_addr_i = a; reg_wdata_i = v; reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] v);
        @(negedge clk_i);
        reg_addr_i = a; reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        @(negedge clk_i);
        v = reg_rdata_o;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
        logic [23:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    task automatic irqchk(input logic exp);
        repeat (2) @(negedge clk_i);
        check(irq_n_o, exp);
    endtask
    // one sample set; the low-pass model advances in step with the design
    task automatic strobe(input int i, input int v);
        @(negedge clk_i);
        sample_stb_i = 1'b1; i_sample_i = '0; i_sample_i[0] = 24'(i);
        v_sample_i = {3{16'(v)}};
        y = y + ((v - y) >>> 4);
        hist.push_back(16'(y));
        @(negedge clk_i);
        sample_stb_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check({8'h00, v_rms_o[0]}, {8'h00, 16'(y)});
        check({8'h00, v_power_o[0]}, {8'h00, 16'(v)});
        check(i_power_o[0], integ ? 24'(acc) : 24'(i));
        acc = int'($signed(24'(acc + (i >>> `INTEG_OUT_SHIFT) - (acc >>> `INTEG_LEAK_SHIFT))));
    endtask
    task automatic run(input int n, input int imag, input int sgn);
        for (int k = 0; k < n; k++)
            for (int j = 0; j < 16; j++)
                strobe((k % 2) ? -imag * sgn : imag * sgn,
                       ((k % 2) ? -sgn : sgn) * int'($urandom_range(16'h2700, 16'h1000)));
    endtask

    initial begin
        #400000;
        num_errors++;
        conclude();
    end
    initial begin
        {ce_i, sample_stb_i, reg_wr_i, reg_rd_i} = 4'b1000;
        {reg_addr_i, reg_wdata_i, i_sample_i, v_sample_i} = '0;
        host_mode = 2'h0; rst_i = 1'b1; y = 0;
        acc = 0;
        integ = 1'b0;
        void'($urandom(32'h34D6));
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        rdchk(`ADDR_GAIN, 24'h000000);
        rdchk(8'hFF, 24'h000000);
        wr(`ADDR_GAIN, 24'h000080);
        rdchk(`ADDR_GAIN, 24'h000080);
        integ = 1'b1;
        repeat (3) strobe(-24'sh100000, 0);
        integ = 1'b0;
        wr(`ADDR_GAIN, 24'h000000);
        wr(`ADDR_PEAK_CURRENT, 24'h000055);
        rdchk(`ADDR_PEAK_CURRENT, 24'h000000);
        wr(`ADDR_OC_THRESHOLD, 24'h000010);
        rdchk(`ADDR_OC_THRESHOLD, 24'h000010);
        wr(`ADDR_MEAS_MODE, 24'h000002);
        strobe(24'h044000, 0);
        rd(`ADDR_STATUS, d); check(d[15], 1'b0);
        wr(`ADDR_MEAS_MODE, 24'h000001);
        strobe(24'h040000, 0);
        rd(`ADDR_STATUS, d); check(d[15], 1'b0);
        strobe(24'h044000, 0);
        rd(`ADDR_STATUS, d); check(d[15], 1'b1);
        wr(`ADDR_MASK, 24'h008000);
        irqchk(1'b0);
        rd(`ADDR_STATUS_CLR, d);
        irqchk(1'b1);
        // crossings: down first, then up, then down again
        wr(`ADDR_LINE_CYCLE, 24'h000001);
        wr(`ADDR_MASK, 24'h000200);
        for (int j = 0; j < 24; j++) strobe(0, -int'($urandom_range(16'h2700, 16'h1000)));
        rd(`ADDR_STATUS_CLR, d);
        rd(`ADDR_STATUS, d); check(d[11:9], 3'b000);
        irqchk(1'b1);
        for (int j = 0; j < 24; j++) strobe(0, int'($urandom_range(16'h2700, 16'h1000)));
        rd(`ADDR_STATUS, d); check(d[11:9], 3'b111);
        irqchk(1'b0);
        rd(`ADDR_STATUS_CLR, d); check(d[11:9], 3'b111);
        rd(`ADDR_STATUS, d); check(d[11:9], 3'b000);
        irqchk(1'b1);
        for (int j = 0; j < 24; j++) strobe(0, -int'($urandom_range(16'h2700, 16'h1000)));
        rd(`ADDR_STATUS, d); check(d[11:9], 3'b000);
        wr(`ADDR_MASK, 24'h000000);
        // peak windows, full scale then a smaller level
        wr(`ADDR_MEAS_MODE, 24'h000004);
        run(6, 24'h2851EC, 1);
        rdchk(`ADDR_PEAK_CURRENT, 24'h0000A1);
        run(6, 24'h100000, -1);
        rdchk(`ADDR_PEAK_CURRENT, 24'h000040);
        rd(`ADDR_STATUS_CLR, d);
        // voltage waveform sampling at each rate
        wr(`ADDR_MASK, 24'h010000);
        for (int r = 0; r < 4; r++) begin
            wr(`ADDR_WAVE_MODE, 24'(r << 5) | 24'h000001);
            words.delete();
            for (int j = 0; j < 16; j++) strobe(0, int'($urandom_range(16'h2700, 0)) - 16'h1380);
            irqchk(1'b0);
            check(words.size() >= (16 >> r) - 1 && words.size() <= (16 >> r) + 1, 1'b1);
            foreach (words[k]) begin
                check(words[k][23:16], {8{words[k][15]}});
                found = 0;
                foreach (hist[h]) if (hist[h] === words[k][15:0]) found = 1;
                check(found[0], 1'b1);
            end
            rd(`ADDR_STATUS_CLR, d);
        end
        // fill the buffer while the host stalls, then drain it
        wr(`ADDR_WAVE_MODE, 24'h000001);
        host_mode = 2'h2;
        repeat (4) @(negedge clk_i);
        words.delete();
        for (int j = 0; j < 8; j++) strobe(0, 16'h0100);
        host_mode = 2'h1;
        repeat (100) @(negedge clk_i);
        check(words.size() >= 4 && words.size() <= 5, 1'b1);
        conclude();
    end
endmodule
